// *** verilog/etc8_timer.sv ***
// 8-bit timer/event counter channel with Avalon-MM register slave
`timescale 1ns/1ps
module etc8_timer
	import etc8_pkg::*;
#(
	parameter int CNT_W = ETC8_CNT_W
) (
	input  wire logic                   sys_clk,             // System clock, 200 MHz
	input  wire logic                   reset,               // Synchronous reset, active high
	input  wire logic                   ce,                  // Clock enable, freezes all state when low
	input  wire logic [ETC8_ADDR_W-1:0] avs_address,         // Byte address
	input  wire logic                   avs_read,            // Read request
	input  wire logic                   avs_write,           // Write request
	input  wire logic [31:0]            avs_writedata,       // Write data
	input  wire logic [3:0]             avs_byteenable,      // Byte enables, lane 0 used
	output logic      [31:0]            avs_readdata,        // Read data
	output logic                        avs_waitrequest,     // Stall
	output logic                        irq,                 // Level interrupt
	input  wire logic                   pin_in,              // Shared pin level, also event input
	output logic                        pin_out,             // Shared pin drive value
	output logic                        pin_oe_n,            // Low while driving the pin
	output logic                        timer_output_signal  // Timer output before the port
);
	if (CNT_W < 2 || CNT_W > 16) begin : g_chk
		$error("etc8_timer: CNT_W must be 2 to 16");
	end

	logic [CNT_W-1:0]      count_r, count_nxt;
	logic [CNT_W-1:0]      cmp_r, cmp_nxt;
	logic [CNT_W-1:0]      cmp_act_r, cmp_act_nxt;
	logic [ETC8_SEL_W-1:0] clksel_r, clksel_nxt;
	etc8_mode_s            mode_r, mode_nxt;
	logic [ETC8_IRQ_W-1:0] status_r, status_nxt, mask_r, mask_nxt, irq_set, irq_clr;
	logic [1:0]            port_r, port_nxt;
	logic                  ff_r, ff_nxt;
	logic                  ack_r, ack_nxt;
	logic [31:0]           rdata_r, rdata_nxt;
	logic                  pin_r, pin_nxt, tout_r, tout_nxt;
	logic                  tick, wr_fire, match, wrap, running;
	etc8_op_e              op;
	etc8_mode_s            wmode;

	etc8_prescale #(
		.DIV_W    (ETC8_DIV_W)
	) i_etc8_prescale (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.ce       (ce),
		.sel      (clksel_r),
		.event_in (pin_in),
		.tick     (tick)
	);

	// One wait state on every access; write lands at the edge waitrequest is low
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_fire         = avs_write & ack_r & avs_byteenable[0];
	assign wmode           = etc8_mode_s'(avs_writedata[7:0] & ETC8_MODE_WMASK);
	assign running         = mode_r.count_enable_bit;
	assign match           = count_r == cmp_act_r;
	assign wrap            = &count_r;

	always_comb begin
		unique case ({mode_r.clear_mode_select, mode_r.pwm_mode_select})
			2'b10:   op = ETC8_FREE;
			2'b11:   op = ETC8_PWM;
			default: op = ETC8_CLEAR;
		endcase
	end

	always_comb begin
		count_nxt   = count_r;
		cmp_nxt     = cmp_r;
		cmp_act_nxt = cmp_act_r;
		clksel_nxt  = clksel_r;
		mode_nxt    = mode_r;
		mask_nxt    = mask_r;
		port_nxt    = port_r;
		ff_nxt      = ff_r;
		irq_set     = '0;
		irq_clr     = '0;
		ack_nxt     = (avs_read | avs_write) & ~ack_r;
		rdata_nxt   = rdata_r;
		// Outside PWM the compare acts at once; software keeps it steady while running
		if (op != ETC8_PWM || !running) begin
			cmp_act_nxt = cmp_r;
		end
		if (!running) begin
			count_nxt = '0;
		end else if (tick) begin
			count_nxt = count_r + 1'b1;
			unique case (op)
				ETC8_CLEAR: begin
					if (match) begin
						count_nxt              = '0;
						irq_set[ETC8_IRQ_MATCH] = 1'b1;
						if (mode_r.timer_output_enable) begin
							ff_nxt = ~ff_r;
						end
					end
				end
				ETC8_FREE: begin
					if (match) begin
						irq_set[ETC8_IRQ_MATCH] = 1'b1;
						if (mode_r.timer_output_enable) begin
							ff_nxt = ~ff_r;
						end
					end
					irq_set[ETC8_IRQ_OVF] = wrap;
				end
				ETC8_PWM: begin
					// New duty only at period end, hence readback may lead the active value
					if (wrap) begin
						cmp_act_nxt          = cmp_r;
						ff_nxt               = mode_r.timer_output_enable & (cmp_r != '0);
						irq_set[ETC8_IRQ_OVF] = 1'b1;
					end else if (match) begin
						ff_nxt                  = 1'b0;
						irq_set[ETC8_IRQ_MATCH] = 1'b1;
					end
				end
			endcase
		end
		if (wr_fire) begin
			unique case (avs_address)
				ETC8_ADDR_COMPARE: cmp_nxt = avs_writedata[CNT_W-1:0];
				ETC8_ADDR_CLKSEL:  clksel_nxt = avs_writedata[ETC8_SEL_W-1:0];
				ETC8_ADDR_MODE: begin
					mode_nxt = wmode;
					if (!wmode.clear_mode_select || !wmode.pwm_mode_select) begin
						if (wmode.flipflop_set_level && !wmode.flipflop_reset_level) begin
							ff_nxt = 1'b1;
						end else if (wmode.flipflop_reset_level && !wmode.flipflop_set_level) begin
							ff_nxt = 1'b0;
						end
					end
				end
				ETC8_ADDR_STATUS:  irq_clr = avs_writedata[ETC8_IRQ_W-1:0];
				ETC8_ADDR_MASK:    mask_nxt = avs_writedata[ETC8_IRQ_W-1:0];
				ETC8_ADDR_PORT:    port_nxt = avs_writedata[1:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		status_nxt = (status_r & ~irq_clr) | irq_set;
		if (avs_read && !ack_r) begin
			unique case (avs_address)
				ETC8_ADDR_COUNT:   rdata_nxt = {{(32-CNT_W){1'b0}}, count_r};
				ETC8_ADDR_COMPARE: rdata_nxt = {{(32-CNT_W){1'b0}}, cmp_r};
				ETC8_ADDR_CLKSEL:  rdata_nxt = {{(32-ETC8_SEL_W){1'b0}}, clksel_r};
				ETC8_ADDR_MODE:    rdata_nxt = {24'h000000, mode_r};
				ETC8_ADDR_STATUS:  rdata_nxt = {{(32-ETC8_IRQ_W){1'b0}}, status_r};
				ETC8_ADDR_MASK:    rdata_nxt = {{(32-ETC8_IRQ_W){1'b0}}, mask_r};
				ETC8_ADDR_PORT:    rdata_nxt = {30'h0, port_r};
				default:           rdata_nxt = 32'h00000000;
			endcase
		end
		// Port latch can force the pin high whatever the timer does
		tout_nxt = ff_nxt & mode_nxt.timer_output_enable;
		pin_nxt  = port_nxt[ETC8_PORT_LATCH] | tout_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			count_r   <= '0;
			cmp_r     <= '0;
			cmp_act_r <= '0;
			clksel_r  <= ETC8_CLKSEL_RST;
			mode_r    <= ETC8_MODE_RST;
			status_r  <= ETC8_IRQ_RST;
			mask_r    <= ETC8_IRQ_RST;
			port_r    <= ETC8_PORT_RST;
			ff_r      <= 1'b0;
			ack_r     <= 1'b0;
			rdata_r   <= 32'h00000000;
			pin_r     <= 1'b0;
			tout_r    <= 1'b0;
		end else if (ce) begin
			count_r   <= count_nxt;
			cmp_r     <= cmp_nxt;
			cmp_act_r <= cmp_act_nxt;
			clksel_r  <= clksel_nxt;
			mode_r    <= mode_nxt;
			status_r  <= status_nxt;
			mask_r    <= mask_nxt;
			port_r    <= port_nxt;
			ff_r      <= ff_nxt;
			ack_r     <= ack_nxt;
			rdata_r   <= rdata_nxt;
			pin_r     <= pin_nxt;
			tout_r    <= tout_nxt;
		end
	end

	assign avs_readdata        = rdata_r;
	assign irq                 = |(status_r & mask_r);
	assign pin_out             = pin_r;
	assign pin_oe_n            = port_r[ETC8_PORT_MODE];
	assign timer_output_signal = tout_r;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_clear_match;
		ce && running && tick && match && op == ETC8_CLEAR;
	endsequence
	sequence s_mode_wr;
		ce && wr_fire && avs_address == ETC8_ADDR_MODE;
	endsequence
	sequence s_rd_cmp;
		ce && avs_read && !ack_r && avs_address == ETC8_ADDR_COMPARE;
	endsequence

	property p_clear_match;
		s_clear_match |=> count_r == '0 && status_r[ETC8_IRQ_MATCH];
	endproperty
	a_clear_match: assert property (p_clear_match) else $error("match did not clear count or flag");

	property p_toggle;
		s_clear_match ##0 mode_r.timer_output_enable && !wr_fire |=> ff_r != $past(ff_r);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output did not toggle on match");

	property p_lvl_pwm;
		s_mode_wr ##0 (wmode.clear_mode_select && wmode.pwm_mode_select && !running) |=> ff_r == $past(ff_r);
	endproperty
	a_lvl_pwm: assert property (p_lvl_pwm) else $error("level bits acted in PWM mode");

	property p_lvl_set;
		s_mode_wr ##0 (!wmode.clear_mode_select && wmode.flipflop_set_level && !wmode.flipflop_reset_level)
			|=> ff_r;
	endproperty
	a_lvl_set: assert property (p_lvl_set) else $error("set level did not set output");

	property p_pin;
		!pin_oe_n && !$past(ce) && port_r[ETC8_PORT_LATCH] || $past(ce) && port_r[ETC8_PORT_LATCH] |-> pin_out;
	endproperty
	a_pin: assert property (p_pin) else $error("port latch high but pin low");

	property p_cmp_read;
		s_rd_cmp |=> avs_readdata == {{(32-CNT_W){1'b0}}, $past(cmp_r)};
	endproperty
	a_cmp_read: assert property (p_cmp_read) else $error("compare read not the written value");

	property p_pwm_hold;
		ce && running && op == ETC8_PWM && !(tick && wrap) |=> cmp_act_r == $past(cmp_act_r);
	endproperty
	a_pwm_hold: assert property (p_pwm_hold) else $error("active compare changed mid period");

	property p_start;
		ce && running && !tick |=> count_r == $past(count_r) || !$past(running);
	endproperty
	a_start: assert property (p_start) else $error("count moved without a count clock");

	property p_w1c;
		ce && wr_fire && avs_address == ETC8_ADDR_STATUS && avs_writedata[ETC8_IRQ_MATCH]
			&& !irq_set[ETC8_IRQ_MATCH] |=> !status_r[ETC8_IRQ_MATCH] ##0 (irq == |(status_r & mask_r));
	endproperty
	a_w1c: assert property (p_w1c) else $error("match flag not cleared by write one");
endmodule : etc8_timer

// *** verilog/etc8_pkg.sv ***
// Constants, register map and types of the 8-bit timer/event counter
package etc8_pkg;
	localparam int ETC8_CNT_W  = 8;
	localparam int ETC8_SEL_W  = 3;
	localparam int ETC8_DIV_W  = 6;
	localparam int ETC8_ADDR_W = 5;
	localparam int ETC8_IRQ_W  = 2;

	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_COUNT   = 5'h00;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_COMPARE = 5'h04;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_CLKSEL  = 5'h08;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_MODE    = 5'h0c;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_STATUS  = 5'h10;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_MASK    = 5'h14;
	localparam logic [ETC8_ADDR_W-1:0] ETC8_ADDR_PORT    = 5'h18;

	localparam int ETC8_IRQ_MATCH = 0;
	localparam int ETC8_IRQ_OVF   = 1;
	localparam int ETC8_PORT_LATCH = 0;
	localparam int ETC8_PORT_MODE  = 1;

	localparam logic [ETC8_SEL_W-1:0] ETC8_SEL_EVENT  = 3'h0;
	localparam logic [ETC8_SEL_W-1:0] ETC8_CLKSEL_RST = 3'h0;
	localparam logic [ETC8_IRQ_W-1:0] ETC8_IRQ_RST    = 2'h0;
	localparam logic [1:0]            ETC8_PORT_RST   = 2'h2;
	localparam logic [7:0]            ETC8_MODE_WMASK = 8'hcf;

	typedef struct packed {
		logic       count_enable_bit;
		logic       clear_mode_select;
		logic [1:0] rsvd;
		logic       flipflop_set_level;
		logic       flipflop_reset_level;
		logic       pwm_mode_select;
		logic       timer_output_enable;
	} etc8_mode_s;

	localparam etc8_mode_s ETC8_MODE_RST = 8'h00;

	typedef enum logic [1:0] {
		ETC8_CLEAR = 2'b00,
		ETC8_FREE  = 2'b10,
		ETC8_PWM   = 2'b11
	} etc8_op_e;
endpackage : etc8_pkg

// *** verilog/etc8_prescale.sv ***
// Count clock selection: free-running divider or edge of the event pin
`timescale 1ns/1ps
module etc8_prescale
	import etc8_pkg::*;
#(
	parameter int DIV_W = ETC8_DIV_W
) (
	input  wire logic                  sys_clk,  // System clock
	input  wire logic                  reset,    // Synchronous reset
	input  wire logic                  ce,       // Clock enable
	input  wire logic [ETC8_SEL_W-1:0] sel,      // Count clock choice
	input  wire logic                  event_in, // External event level
	output logic                       tick      // One-cycle count clock pulse
);
	if (DIV_W < 6) begin : g_chk
		$error("etc8_prescale: DIV_W must be at least 6");
	end

	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_nxt;
	logic [DIV_W-1:0] div_mask;
	logic             event_r;
	logic             event_nxt;
	logic             tick_r;
	logic             tick_nxt;

	// Divider runs free, so a start lands anywhere in a count clock period
	always_comb begin
		div_nxt   = div_r + 1'b1;
		event_nxt = event_in;
		for (int i = 0; i < DIV_W; i++) begin
			div_mask[i] = (i < int'(sel) - 1);
		end
		if (sel == ETC8_SEL_EVENT) begin
			tick_nxt = event_in & ~event_r;
		end else begin
			tick_nxt = (div_r & div_mask) == div_mask;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			div_r   <= '0;
			// Reset high so a pin already high at release is not taken as an edge
			event_r <= 1'b1;
			tick_r  <= 1'b0;
		end else if (ce) begin
			div_r   <= div_nxt;
			event_r <= event_nxt;
			tick_r  <= tick_nxt;
		end
	end

	assign tick = tick_r;
endmodule : etc8_prescale

// *** tb/etc8_timer_tb.sv ***
// Self-checking register-level testbench of the 8-bit timer/event counter
`timescale 1ns/1ps
module etc8_timer_tb;
	import etc8_pkg::*;

	logic                   sys_clk;
	logic                   reset;
	logic                   ce;
	logic [ETC8_ADDR_W-1:0] avs_address;
	logic                   avs_read;
	logic                   avs_write;
	logic [31:0]            avs_writedata;
	logic [3:0]             avs_byteenable;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   irq;
	logic                   pin_in;
	logic                   pin_out;
	logic                   pin_oe_n;
	logic                   timer_output_signal;
	logic [3:0]             be;
	logic [31:0]            q;
	logic [31:0]            q1;
	logic [31:0]            hi;
	int                     bad_count;
	int                     n_checks;

	etc8_timer i_etc8_timer (
		.sys_clk             (sys_clk),
		.reset               (reset),
		.ce                  (ce),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_byteenable      (avs_byteenable),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.irq                 (irq),
		.pin_in              (pin_in),
		.pin_out             (pin_out),
		.pin_oe_n            (pin_oe_n),
		.timer_output_signal (timer_output_signal)
	);

	always #2.5 sys_clk = ~sys_clk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Entered just after a rising edge; request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic [ETC8_ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		int   n;
		logic done;
		avs_address    <= a;
		avs_write      <= w;
		avs_read       <= ~w;
		avs_writedata  <= d;
		avs_byteenable <= be;
		done = 1'b0;
		for (n = 0; n < 20 && !done; n++) begin
			@(posedge sys_clk);
			done = (avs_waitrequest === 1'b0);
			q = avs_readdata;
		end
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		// One idle edge so the next call never re-raises a strobe in this time step
		@(posedge sys_clk);
		if (!done) begin
			check(32'h0, 32'h1);
			finish_test();
		end
	endtask : bus

	task automatic wr(input logic [ETC8_ADDR_W-1:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr

	task automatic rd_chk(input logic [ETC8_ADDR_W-1:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check(q, exp);
	endtask : rd_chk

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_clk

	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hf;
		pin_in = 1'b0;
		be = 4'hf;
		bad_count = 0;
		n_checks = 0;
		wait_clk(20);
		reset <= 1'b0;
		wait_clk(1);
		rd_chk(ETC8_ADDR_COUNT, 32'h0);
		rd_chk(ETC8_ADDR_CLKSEL, 32'h0);
		rd_chk(ETC8_ADDR_MODE, 32'h0);
		rd_chk(ETC8_ADDR_STATUS, 32'h0);
		rd_chk(ETC8_ADDR_PORT, 32'h2);
		check({31'h0, pin_oe_n}, 32'h1);
		// Clear mode, compare 2, one tick per cycle; mode set up in four ordered writes
		wr(ETC8_ADDR_COMPARE, 32'h2);
		wr(ETC8_ADDR_CLKSEL, 32'h1);
		wr(ETC8_ADDR_MODE, 32'h00);
		wr(ETC8_ADDR_MODE, 32'h01);
		wr(ETC8_ADDR_MODE, 32'h09);
		wait_clk(3);
		check({31'h0, timer_output_signal}, 32'h1);
		wr(ETC8_ADDR_MODE, 32'h89);
		repeat (4) begin
			bus(ETC8_ADDR_COUNT, 1'b0, 32'h0);
			check({31'h0, q <= 32'h2}, 32'h1);
		end
		wr(ETC8_ADDR_MODE, 32'h09);
		rd_chk(ETC8_ADDR_COUNT, 32'h0);
		rd_chk(ETC8_ADDR_STATUS, 32'h1);
		check({31'h0, irq}, 32'h0);
		wr(ETC8_ADDR_MASK, 32'h1);
		wait_clk(2);
		check({31'h0, irq}, 32'h1);
		wr(ETC8_ADDR_STATUS, 32'h1);
		wait_clk(2);
		check({31'h0, irq}, 32'h0);
		rd_chk(ETC8_ADDR_STATUS, 32'h0);
		// Reset level outside PWM forces the flip-flop low
		wr(ETC8_ADDR_MODE, 32'h05);
		wait_clk(3);
		check({31'h0, timer_output_signal}, 32'h0);
		check({31'h0, pin_out}, 32'h0);
		wr(ETC8_ADDR_PORT, 32'h1);
		wait_clk(3);
		check({30'h0, pin_oe_n, pin_out}, 32'h1);
		wr(ETC8_ADDR_PORT, 32'h2);
		// Event counting on the pin: match only on the third rising edge
		wr(ETC8_ADDR_CLKSEL, {29'h0, ETC8_SEL_EVENT});
		wr(ETC8_ADDR_MODE, 32'h01);
		wr(ETC8_ADDR_MODE, 32'h81);
		repeat (2) begin
			pin_in <= 1'b1;
			wait_clk(4);
			pin_in <= 1'b0;
			wait_clk(4);
		end
		rd_chk(ETC8_ADDR_STATUS, 32'h0);
		pin_in <= 1'b1;
		wait_clk(4);
		pin_in <= 1'b0;
		wait_clk(4);
		rd_chk(ETC8_ADDR_STATUS, 32'h1);
		check({31'h0, irq}, 32'h1);
		wr(ETC8_ADDR_MODE, 32'h01);
		wait_clk(3);
		check({31'h0, timer_output_signal}, 32'h1);
		wr(ETC8_ADDR_CLKSEL, 32'h7);
		rd_chk(ETC8_ADDR_CLKSEL, 32'h7);
		wr(ETC8_ADDR_CLKSEL, 32'h1);
		// PWM: level bits have no effect, compare reads give the written value
		wr(ETC8_ADDR_MODE, 32'h42);
		wr(ETC8_ADDR_MODE, 32'h43);
		wr(ETC8_ADDR_MODE, 32'h47);
		wait_clk(3);
		check({31'h0, timer_output_signal}, 32'h1);
		wr(ETC8_ADDR_COMPARE, 32'h80);
		rd_chk(ETC8_ADDR_COMPARE, 32'h80);
		be = 4'h0;
		wr(ETC8_ADDR_COMPARE, 32'h11);
		be = 4'hf;
		rd_chk(ETC8_ADDR_COMPARE, 32'h80);
		rd_chk(5'h1c, 32'h0);
		// PWM running: readback leads the active compare, new duty only from the next period
		wr(ETC8_ADDR_MODE, 32'hc7);
		wr(ETC8_ADDR_COMPARE, 32'h20);
		wr(ETC8_ADDR_COMPARE, 32'h10);
		rd_chk(ETC8_ADDR_COMPARE, 32'h10);
		wait_clk(300);
		hi = 32'h0;
		repeat (256) begin
			@(posedge sys_clk);
			hi = hi + {31'h0, timer_output_signal};
		end
		check(hi, 32'h11);
		rd_chk(ETC8_ADDR_STATUS, 32'h3);
		check({31'h0, irq}, 32'h1);
		wr(ETC8_ADDR_MODE, 32'h47);
		wr(ETC8_ADDR_STATUS, 32'h3);
		// Free run passes the compare value, and a low clock enable freezes the count
		wr(ETC8_ADDR_MODE, 32'h40);
		wr(ETC8_ADDR_MODE, 32'h41);
		wr(ETC8_ADDR_MODE, 32'h49);
		wr(ETC8_ADDR_MODE, 32'hc9);
		wait_clk(40);
		bus(ETC8_ADDR_COUNT, 1'b0, 32'h0);
		q1 = q;
		check({31'h0, q1 > 32'h10}, 32'h1);
		ce <= 1'b0;
		wait_clk(50);
		ce <= 1'b1;
		bus(ETC8_ADDR_COUNT, 1'b0, 32'h0);
		check({31'h0, (q - q1) < 32'h8}, 32'h1);
		wait_clk(300);
		rd_chk(ETC8_ADDR_STATUS, 32'h3);
		// Reset in mid-run brings every register back to its reset value
		reset <= 1'b1;
		wait_clk(2);
		reset <= 1'b0;
		wait_clk(1);
		rd_chk(ETC8_ADDR_MODE, 32'h0);
		rd_chk(ETC8_ADDR_COUNT, 32'h0);
		rd_chk(ETC8_ADDR_STATUS, 32'h0);
		check({30'h0, pin_oe_n, timer_output_signal}, 32'h2);
		finish_test();
	end
endmodule : etc8_timer_tb
